/* File: hw/tmcg_pkg.sv */
package tmcg_pkg;
   // Register indices, byte address is four times the index
   localparam logic [2:0] IDX_CNT_HI = 3'h0;
   localparam logic [2:0] IDX_CNT_LO = 3'h1;
   localparam logic [2:0] IDX_RLD_HI = 3'h2;
   localparam logic [2:0] IDX_RLD_LO = 3'h3;
   localparam logic [2:0] IDX_PWM_HI = 3'h4;
   localparam logic [2:0] IDX_PWM_LO = 3'h5;
   localparam logic [2:0] IDX_CTL0 = 3'h6;
   localparam logic [2:0] IDX_CTL1 = 3'h7;

   // Reset and restart values
   localparam logic [15:0] CNT_RESET = 16'h0001;
   localparam logic [15:0] CNT_RESTART = 16'h0001;
   localparam logic [15:0] RLD_RESET = 16'hFFFF;
   localparam logic [15:0] PWM_RESET = 16'h0000;

   // Control register zero field positions
   localparam int unsigned CTL0_MSB_BIT = 7;
   localparam int unsigned CTL0_ISEL_LSB = 5;
   localparam int unsigned CTL0_PWMD_LSB = 1;
   localparam int unsigned CTL0_FLAG_BIT = 0;

   // Control register one field positions
   localparam int unsigned CTL1_EN_BIT = 7;
   localparam int unsigned CTL1_POL_BIT = 6;
   localparam int unsigned CTL1_PSC_LSB = 3;
   localparam int unsigned CTL1_MODE_LSB = 0;

   // Operating modes, mode_select_msb in bit 3
   localparam logic [3:0] MODE_COMPARE = 4'h2;
   localparam logic [3:0] MODE_GATED = 4'h6;
   localparam logic [3:0] MODE_CAPCMP = 4'h7;
   localparam logic [3:0] MODE_DUALPWM = 4'h8;
   localparam logic [3:0] MODE_CAPRST = 4'h9;

   // Interrupt source select encodings
   localparam logic [1:0] ISEL_INPUT = 2'h2;
   localparam logic [1:0] ISEL_RELOAD = 2'h3;

   // Software control fields
   typedef struct packed {
      logic en;
      logic pol;
      logic [2:0] psc;
      logic [3:0] mode;
      logic [1:0] isel;
      logic [2:0] pwmd;
   } tmcg_ctl_t;

   localparam tmcg_ctl_t CTL_RESET = '0;

   // Run state, Gray coded
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN = 2'b11
   } tmcg_state_t;
endpackage

/* File: hw/tmcg_timer.sv */
`timescale 1ns/1ps
// What this block does
// - Capture-restart edge copies count into the PWM pair.
// - Capture raises interrupt, restarts count at 0001H, sets capture flag.
// - Capture-restart reaching reload raises interrupt, restarts, clears flag.
// - Polarity bit picks rising or falling capture edge.
// - Compare mode interrupts at compare value and keeps counting.
// - Compare mode toggles output at each compare match.
// - Compare mode wraps FFFFH to 0000H and continues.
// - Gated mode counts only while input sits at asserted level.
// - Gated mode interrupts on input deassertion and on reload.
// - Gated reload interrupts, restarts at 0001H, counts while asserted.
// - Gated mode toggles output at each reload restart.
// - Software start count applies to first pass only.
// - Capture/compare starts on first edge without interrupt.
// - Later capture/compare edges capture, interrupt, restart, set flag.
// - Capture/compare reaching compare value interrupts, restarts, clears flag.
// - Interrupt covers both event classes unless select restricts it.
// - Select 0x all events, 10 input only, 11 reload only.
// - High byte read while enabled latches low byte for next read.
// - Count reads never disturb timer operation.
// - Low byte read while disabled returns live count.
// - Output toggles every time the counter reloads.
// - Shared pin is timer input except in dual-PWM mode.
// - Count byte write replaces that byte at next edge.
module tmcg_timer #(
   parameter int unsigned ADDR_W = 12
) (
   input wire logic CLK_I,                    // System clock
   input wire logic RESETN_I,                 // Async reset, active low
   input wire logic PSEL_I,                   // APB select
   input wire logic PENABLE_I,                // APB enable
   input wire logic PWRITE_I,                 // APB direction
   input wire logic [ADDR_W-1:0] PADDR_I,     // APB byte address
   input wire logic [31:0] PWDATA_I,          // APB write data
   input wire logic [3:0] PSTRB_I,            // APB byte strobes
   output logic [31:0] PRDATA_O,              // APB read data
   output logic PREADY_O,                     // APB ready
   output logic PSLVERR_O,                    // APB error
   input wire logic TIN_I,                    // Timer input pin level
   output logic TOUT_O,                       // Timer output level
   output logic TIN_PIN_O,                    // Complement output level
   output logic TIN_PIN_OE_O,                 // Complement output drive
   output logic TIMER_IRQ_O                   // Timer interrupt pulse
);
   import tmcg_pkg::*;

   // Register index match
   function automatic logic hit(input logic [2:0] a, input logic [2:0] i);
      return a == i;
   endfunction

   logic [15:0] cnt_r, cnt_nxt;
   logic [15:0] rld_r, rld_nxt;
   logic [7:0] rld_tmp_r, rld_tmp_nxt;
   logic [15:0] pwm_r, pwm_nxt;
   logic [7:0] hold_r, hold_nxt;
   tmcg_ctl_t ctl_r, ctl_nxt;
   logic flag_r, flag_nxt;
   logic tout_r, tout_nxt;
   logic [6:0] psc_r, psc_nxt;
   tmcg_state_t st_r, st_nxt;
   logic sync1_r, sync2_r, prev_r;
   logic irq_r, irq_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic [2:0] idx;
   logic bad, wr_ok, rd_take;
   logic [7:0] wdat, rd_val;
   logic rise, fall, sel_edge, deassert, gate_lvl;
   logic [6:0] pmask;
   logic tick, at_rld, cap_ev, rld_ev, inp_ev, restart, cnt_wr;

   // APB decode, one wait state per access
   assign idx = PADDR_I[4:2];
   assign bad = (PADDR_I[1:0] != 2'h0) || (PADDR_I[ADDR_W-1:5] != '0);
   assign wr_ok = PSEL_I && PENABLE_I && pready_r && PWRITE_I && !bad
                  && PSTRB_I[0];
   assign rd_take = PSEL_I && PENABLE_I && !pready_r && !PWRITE_I;
   assign wdat = PWDATA_I[7:0];
   assign cnt_wr = wr_ok && (hit(idx, IDX_CNT_HI) || hit(idx, IDX_CNT_LO));

   always_comb begin
      rd_val = 8'h00;
      case (idx)
         IDX_CNT_HI: rd_val = cnt_r[15:8];
         IDX_CNT_LO: rd_val = ctl_r.en ? hold_r : cnt_r[7:0];
         IDX_RLD_HI: rd_val = rld_r[15:8];
         IDX_RLD_LO: rd_val = rld_r[7:0];
         IDX_PWM_HI: rd_val = pwm_r[15:8];
         IDX_PWM_LO: rd_val = pwm_r[7:0];
         IDX_CTL0: rd_val = {ctl_r.mode[3], ctl_r.isel, 1'b0, ctl_r.pwmd,
                             flag_r};
         IDX_CTL1: rd_val = {ctl_r.en, ctl_r.pol, ctl_r.psc,
                             ctl_r.mode[2:0]};
         default: rd_val = 8'h00;
      endcase
   end

   // Bus answer next values
   always_comb begin
      pready_nxt = 1'b0;
      pslverr_nxt = 1'b0;
      prdata_nxt = prdata_r;
      if (PSEL_I && PENABLE_I && !pready_r) begin
         pready_nxt = 1'b1;
         pslverr_nxt = bad;
         prdata_nxt = bad ? 32'h0000_0000 : {24'h00_0000, rd_val};
      end
   end

   // Input edge and level decode
   assign rise = sync2_r && !prev_r;
   assign fall = !sync2_r && prev_r;
   assign sel_edge = ctl_r.pol ? rise : fall;
   assign deassert = ctl_r.pol ? fall : rise;
   assign gate_lvl = sync2_r == ctl_r.pol;

   assign pmask = 7'((8'h01 << ctl_r.psc) - 8'h01);
   assign tick = ctl_r.en && ((psc_r & pmask) == pmask);
   assign psc_nxt = (ctl_r.en && !tick) ? 7'(psc_r + 7'h01) : 7'h00;
   assign at_rld = cnt_r == rld_r;

   // Mode engine: events and run state
   always_comb begin
      st_nxt = st_r;
      cap_ev = 1'b0;
      rld_ev = 1'b0;
      inp_ev = 1'b0;
      restart = 1'b0;
      if (!ctl_r.en) begin
         st_nxt = ST_IDLE;
      end else begin
         case (st_r)
            ST_IDLE: st_nxt = (ctl_r.mode == MODE_CAPCMP) ? ST_WAIT : ST_RUN;
            ST_WAIT: if (sel_edge) begin
               st_nxt = ST_RUN;
            end
            ST_RUN: begin
               case (ctl_r.mode)
                  MODE_CAPRST, MODE_CAPCMP: begin
                     if (sel_edge) begin
                        cap_ev = 1'b1;
                        inp_ev = 1'b1;
                     end else if (tick && at_rld) begin
                        rld_ev = 1'b1;
                        restart = 1'b1;
                     end
                  end
                  MODE_COMPARE: rld_ev = tick && at_rld;
                  MODE_GATED: begin
                     inp_ev = deassert;
                     if (tick && gate_lvl && at_rld) begin
                        rld_ev = 1'b1;
                        restart = 1'b1;
                     end
                  end
                  default: if (tick && at_rld) begin
                     rld_ev = 1'b1;
                     restart = 1'b1;
                  end
               endcase
            end
            default: st_nxt = ST_IDLE;
         endcase
      end
   end

   // Counter, capture, flag and output next values
   always_comb begin
      cnt_nxt = cnt_r;
      pwm_nxt = pwm_r;
      flag_nxt = flag_r;
      tout_nxt = tout_r;
      if (wr_ok && hit(idx, IDX_PWM_HI)) begin
         pwm_nxt[15:8] = wdat;
      end
      if (wr_ok && hit(idx, IDX_PWM_LO)) begin
         pwm_nxt[7:0] = wdat;
      end
      if (wr_ok && hit(idx, IDX_CTL0)) begin
         flag_nxt = wdat[CTL0_FLAG_BIT];
      end
      if (st_r == ST_RUN && tick
          && (ctl_r.mode != MODE_GATED || gate_lvl)) begin
         cnt_nxt = 16'(cnt_r + 16'h0001);
      end
      if (cap_ev) begin
         pwm_nxt = cnt_r;
         cnt_nxt = CNT_RESTART;
         flag_nxt = 1'b1;
      end
      if (restart) begin
         cnt_nxt = CNT_RESTART;
      end
      if (rld_ev) begin
         flag_nxt = 1'b0;
      end
      if (rld_ev) begin
         tout_nxt = !tout_r;
      end
      if (!ctl_r.en) begin
         tout_nxt = ctl_r.pol;
      end
      if (wr_ok && hit(idx, IDX_CNT_HI)) begin
         cnt_nxt[15:8] = wdat;
      end
      if (wr_ok && hit(idx, IDX_CNT_LO)) begin
         cnt_nxt[7:0] = wdat;
      end
   end

   assign irq_nxt = (inp_ev && ctl_r.isel != ISEL_RELOAD)
                    || (rld_ev && ctl_r.isel != ISEL_INPUT);

   // Holding latch and software registers
   always_comb begin
      hold_nxt = hold_r;
      rld_nxt = rld_r;
      rld_tmp_nxt = rld_tmp_r;
      ctl_nxt = ctl_r;
      // latch low byte on high read
      if (rd_take && !bad && hit(idx, IDX_CNT_HI) && ctl_r.en) begin
         hold_nxt = cnt_r[7:0];
      end
      if (wr_ok && hit(idx, IDX_RLD_HI)) begin
         rld_tmp_nxt = wdat;
      end
      if (wr_ok && hit(idx, IDX_RLD_LO)) begin
         rld_nxt = {rld_tmp_r, wdat};
      end
      if (wr_ok && hit(idx, IDX_CTL0)) begin
         ctl_nxt.mode[3] = wdat[CTL0_MSB_BIT];
         ctl_nxt.isel = wdat[CTL0_ISEL_LSB +: 2];
         ctl_nxt.pwmd = wdat[CTL0_PWMD_LSB +: 3];
      end
      if (wr_ok && hit(idx, IDX_CTL1)) begin
         ctl_nxt.en = wdat[CTL1_EN_BIT];
         ctl_nxt.pol = wdat[CTL1_POL_BIT];
         ctl_nxt.psc = wdat[CTL1_PSC_LSB +: 3];
         ctl_nxt.mode[2:0] = wdat[CTL1_MODE_LSB +: 3];
      end
   end

   // State registers
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         cnt_r <= CNT_RESET;
         rld_r <= RLD_RESET;
         rld_tmp_r <= RLD_RESET[15:8];
         pwm_r <= PWM_RESET;
         hold_r <= 8'h00;
         ctl_r <= CTL_RESET;
         flag_r <= 1'b0;
         tout_r <= 1'b0;
         psc_r <= 7'h00;
         st_r <= ST_IDLE;
         irq_r <= 1'b0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         cnt_r <= cnt_nxt;
         rld_r <= rld_nxt;
         rld_tmp_r <= rld_tmp_nxt;
         pwm_r <= pwm_nxt;
         hold_r <= hold_nxt;
         ctl_r <= ctl_nxt;
         flag_r <= flag_nxt;
         tout_r <= tout_nxt;
         psc_r <= psc_nxt;
         st_r <= st_nxt;
         irq_r <= irq_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         sync1_r <= TIN_I;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   // Port drive
   assign PRDATA_O = prdata_r;
   assign PREADY_O = pready_r;
   assign PSLVERR_O = pslverr_r;
   assign TOUT_O = tout_r;
   assign TIMER_IRQ_O = irq_r;
   // pin turns output only in dual-PWM
   assign TIN_PIN_OE_O = ctl_r.mode == MODE_DUALPWM;
   assign TIN_PIN_O = !tout_r;

   // Checks
   property p_cap_copy;
      @(posedge CLK_I) disable iff (!RESETN_I)
      cap_ev |=> pwm_r == $past(cnt_r);
   endproperty
   a_cap_copy: assert property (p_cap_copy)
      else $error("capture value not stored");

   property p_cap_restart;
      @(posedge CLK_I) disable iff (!RESETN_I)
      (cap_ev && !cnt_wr) |=> (cnt_r == CNT_RESTART) && flag_r;
   endproperty
   a_cap_restart: assert property (p_cap_restart)
      else $error("capture did not restart or set flag");

   property p_rld_restart;
      @(posedge CLK_I) disable iff (!RESETN_I)
      (restart && !cnt_wr) |=> (cnt_r == CNT_RESTART) && !flag_r;
   endproperty
   a_rld_restart: assert property (p_rld_restart)
      else $error("reload did not restart or clear flag");

   property p_cmp_keep;
      @(posedge CLK_I) disable iff (!RESETN_I)
      (ctl_r.mode == MODE_COMPARE && st_r == ST_RUN && tick && !cnt_wr)
      |=> cnt_r == 16'($past(cnt_r) + 16'h0001);
   endproperty
   a_cmp_keep: assert property (p_cmp_keep)
      else $error("compare mode count not incremented");

   property p_gate_hold;
      @(posedge CLK_I) disable iff (!RESETN_I)
      (ctl_r.mode == MODE_GATED && !gate_lvl && !cnt_wr) |=> $stable(cnt_r);
   endproperty
   a_gate_hold: assert property (p_gate_hold)
      else $error("gated count moved while input idle");

   property p_toggle;
      @(posedge CLK_I) disable iff (!RESETN_I)
      (rld_ev && ctl_r.en) |=> TOUT_O != $past(TOUT_O);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("output did not toggle on reload");

   property p_irq_sel;
      @(posedge CLK_I) disable iff (!RESETN_I)
      ((inp_ev || rld_ev) ##1 1'b1) or (!(inp_ev || rld_ev) ##1 !TIMER_IRQ_O);
   endproperty
   a_irq_sel: assert property (p_irq_sel)
      else $error("interrupt without event");

   property p_irq_filter;
      @(posedge CLK_I) disable iff (!RESETN_I)
      (inp_ev && !rld_ev && ctl_r.isel == ISEL_RELOAD) |=> !TIMER_IRQ_O;
   endproperty
   a_irq_filter: assert property (p_irq_filter)
      else $error("input event passed reload-only filter");

   property p_hold;
      @(posedge CLK_I) disable iff (!RESETN_I)
      (rd_take && !bad && idx == IDX_CNT_HI && ctl_r.en)
      |=> hold_r == $past(cnt_r[7:0]);
   endproperty
   a_hold: assert property (p_hold)
      else $error("low byte not latched on high read");

   property p_first_edge;
      @(posedge CLK_I) disable iff (!RESETN_I)
      (st_r == ST_WAIT && ctl_r.en && sel_edge)
      |=> st_r == ST_RUN ##0 !TIMER_IRQ_O;
   endproperty
   a_first_edge: assert property (p_first_edge)
      else $error("first edge mishandled");
endmodule // tmcg_timer

/* File: tb/tmcg_tin_src.sv */
`timescale 1ns/1ps
// Outside source of the timer input, prompt or slow
module tmcg_tin_src (
   input wire logic clk_i,        // Bench clock
   input wire logic rst_n_i,      // Reset, active low
   input wire logic lvl_i,        // Requested pin level
   input wire logic [3:0] lag_i,  // Extra cycles before a change
   output logic tin_o             // Level seen on the pin
);
   logic [3:0] wait_r;

   // Follow the request once the lag has run out
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tin_o <= 1'b0;
         wait_r <= 4'h0;
      end else if (lvl_i == tin_o) begin
         wait_r <= 4'h0;
      end else if (wait_r >= lag_i) begin
         tin_o <= lvl_i;
         wait_r <= 4'h0;
      end else begin
         wait_r <= wait_r + 4'h1;
      end
   end
endmodule // tmcg_tin_src

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
   import tmcg_pkg::*;
   logic clk, rst_n, psel, pen, pwr, tin_lvl, e;
   logic pready, pslverr, tin, tout, pin_o, oe, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb, tin_lag;
   logic [7:0] q, q1;
   logic [15:0] v, w;
   logic [1:0] isels [3];
   int errors, num_checks, irqs, i0, cyc, seed;

   tmcg_timer #(.ADDR_W(12)) dut (
      .CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .TIN_I(tin), .TOUT_O(tout),
      .TIN_PIN_O(pin_o), .TIN_PIN_OE_O(oe), .TIMER_IRQ_O(irq));

   tmcg_tin_src src (.clk_i(clk), .rst_n_i(rst_n), .lvl_i(tin_lvl),
      .lag_i(tin_lag), .tin_o(tin));

   // Clock source
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Interrupt pulse count and hang guard, away from the launch edge
   always @(negedge clk) begin
      cyc <= cyc + 1;
      if (irq === 1'b1) irqs <= irqs + 1;
      if (cyc == 6000) begin
         errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rng(input logic [15:0] x, lo, hi);
      chk(16'((x >= lo) && (x <= hi)), 16'h0001);
   endtask

   task automatic cy(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One bus transfer, held until ready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [7:0] d);
      int n;
      logic rdy;
      n = 0;
      rdy = 1'b0;
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= 32'(d);
      @(posedge clk);
      pen <= 1'b1;
      // Ready and data read mid-cycle, as they stand at the next edge
      do begin
         @(negedge clk);
         rdy = pready;
         q = prdata[7:0];
         e = pslverr;
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      if (rdy !== 1'b1) errors++;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [2:0] i, input logic [7:0] d);
      apb(1'b1, {7'h00, i, 2'h0}, d);
   endtask

   task automatic rd(input logic [2:0] i);
      apb(1'b0, {7'h00, i, 2'h0}, 8'h00);
   endtask

   task automatic rd16(input logic [2:0] i);
      rd(i);
      v[15:8] = q;
      rd(i + 3'h1);
      v[7:0] = q;
   endtask

   task automatic pin(input logic l);
      tin_lvl <= l;
      cy(1);
   endtask

   // set up while stopped, capture pair cleared, enable last
   task automatic cfg(input logic [7:0] c0, c1, input logic [15:0] c, r);
      wr(IDX_CTL1, 8'h00);
      wr(IDX_CTL0, c0);
      wr(IDX_CTL1, c1);
      wr(IDX_CNT_HI, c[15:8]);
      wr(IDX_CNT_LO, c[7:0]);
      wr(IDX_RLD_HI, r[15:8]);
      wr(IDX_RLD_LO, r[7:0]);
      wr(IDX_PWM_HI, 8'h00);
      wr(IDX_PWM_LO, 8'h00);
      wr(IDX_CTL1, c1 | 8'h80);
      i0 = irqs;
   endtask

   // interrupts let through by the source select
   function automatic logic [15:0] nirq(input logic [1:0] s,
                                        input int inp, input int rld);
      nirq = 16'(s[1] ? (s[0] ? rld : inp) : inp + rld);
   endfunction

   initial begin
      seed = 74705;
      {psel, pen, pwr, tin_lvl, rst_n} = '0;
      {paddr, pwdata} = '0;
      pstrb = 4'hF;
      isels = '{2'h0, 2'h2, 2'h3};
      w = 16'($random(seed));
      tin_lag = {2'h0, w[1:0]};
      cy(10);
      rst_n <= 1'b1;
      cy(1);
      // Reset values, then an unmapped place
      for (int i = 0; i < 8; i++) begin
         rd(3'(i));
         chk(16'(q), (i == 1) ? 16'h0001
             : (i == 2 || i == 3) ? 16'h00FF : 16'h0000);
      end
      apb(1'b0, 12'h020, 8'h00);
      chk({e, q}, 16'h0100);
      // Random values through the paired registers
      for (int i = 0; i < 4; i++) begin
         w = 16'($random(seed));
         wr(IDX_RLD_HI, w[15:8]);
         wr(IDX_RLD_LO, w[7:0]);
         rd16(IDX_RLD_HI);
         chk(v, w);
         wr(IDX_PWM_HI, w[7:0]);
         wr(IDX_PWM_LO, w[15:8]);
         rd16(IDX_PWM_HI);
         chk(v, {w[7:0], w[15:8]});
      end
      // Capture-restart on rising edges
      cfg(8'h80, 8'h41, 16'h0001, 16'h0100);
      chk(16'(oe), 16'h0000);
      cy(40);
      pin(1'b1);
      cy(10);
      chk(16'(irqs - i0), 16'h0001);
      rd(IDX_CTL0);
      chk(16'(q[0]), 16'h0001);
      rd16(IDX_PWM_HI);
      rng(v, 16'h0028, 16'h0040);
      rd16(IDX_CNT_HI);
      rng(v, 16'h0001, 16'h0020);
      pin(1'b0);
      cy(300);
      chk(16'(irqs - i0), 16'h0002);
      rd(IDX_CTL0);
      chk(16'(q[0]), 16'h0000);
      // Compare mode through the wrap
      cfg(8'h00, 8'h02, 16'hFFF0, 16'h0008);
      chk(16'(tout), 16'h0000);
      cy(40);
      chk(16'(irqs - i0), 16'h0001);
      chk(16'(tout), 16'h0001);
      chk(16'(pin_o), 16'h0000);
      rd16(IDX_CNT_HI);
      rng(v, 16'h0009, 16'h0040);
      rd(IDX_CNT_HI);
      cy(20);
      rd(IDX_CNT_LO);
      q1 = q;
      rd(IDX_CNT_LO);
      chk(16'(q), 16'(q1));
      wr(IDX_CNT_HI, 8'h5A);
      rd(IDX_CNT_HI);
      chk(16'(q), 16'h005A);
      wr(IDX_CTL1, 8'h02);
      wr(IDX_CNT_LO, 8'h34);
      rd(IDX_CNT_LO);
      chk(16'(q), 16'h0034);
      // Dual-PWM turns the shared pin around
      wr(IDX_CTL1, 8'h00);
      wr(IDX_CTL0, 8'h80);
      chk(16'(oe), 16'h0001);
      // Prescale of 128
      cfg(8'h00, 8'h3A, 16'h0001, 16'hFFFF);
      cy(500);
      rd16(IDX_CNT_HI);
      rng(v, 16'h0004, 16'h0006);
      // Gated mode under each source select
      for (int k = 0; k < 3; k++) begin
         cfg({1'b0, isels[k], 5'h00}, 8'h46, 16'h0010, 16'h0020);
         cy(20);
         rd16(IDX_CNT_HI);
         chk(v, 16'h0010);
         pin(1'b1);
         cy(10);
         pin(1'b0);
         cy(10);
         chk(16'(irqs - i0), nirq(isels[k], 1, 0));
         rd16(IDX_CNT_HI);
         w = v;
         cy(10);
         rd16(IDX_CNT_HI);
         chk(v, w);
         i0 = irqs;
         pin(1'b1);
         cy(30);
         pin(1'b0);
         cy(10);
         chk(16'(irqs - i0), nirq(isels[k], 1, 1));
         chk(16'(tout), 16'h0000);
         rd16(IDX_CNT_HI);
         rng(v, 16'h0012, 16'h001F);
      end
      // Capture/compare on falling edges
      pin(1'b1);
      cy(5);
      cfg(8'h00, 8'h07, 16'h0001, 16'h0040);
      cy(20);
      rd16(IDX_CNT_HI);
      chk(v, 16'h0001);
      pin(1'b0);
      cy(10);
      chk(16'(irqs - i0), 16'h0000);
      pin(1'b1);
      cy(20);
      chk(16'(irqs - i0), 16'h0000);
      pin(1'b0);
      cy(8);
      chk(16'(irqs - i0), 16'h0001);
      rd(IDX_CTL0);
      chk(16'(q[0]), 16'h0001);
      rd16(IDX_PWM_HI);
      rng(v, 16'h001A, 16'h0028);
      cy(70);
      chk(16'(irqs - i0), 16'h0002);
      rd(IDX_CTL0);
      chk(16'(q[0]), 16'h0000);
      report_and_stop();
   end
endmodule // tb
